// ==== inc/ufc_pkg.sv ====
// Package with register map, reset values, field positions and types of the flow control block.
package ufc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_DIVISOR_LOW  = 5'h00;
  localparam logic [4:0] ADDR_DIVISOR_HIGH = 5'h01;
  localparam logic [4:0] ADDR_IRQ_ENABLE   = 5'h02;
  localparam logic [4:0] ADDR_IRQ_IDENT    = 5'h03;
  localparam logic [4:0] ADDR_FIFO_CTRL    = 5'h04;
  localparam logic [4:0] ADDR_LINE_CTRL    = 5'h05;
  localparam logic [4:0] ADDR_MODEM_CTRL   = 5'h06;
  localparam logic [4:0] ADDR_LINE_STAT    = 5'h07;
  localparam logic [4:0] ADDR_MODEM_STAT   = 5'h08;
  localparam logic [4:0] ADDR_SCRATCH      = 5'h09;
  localparam logic [4:0] ADDR_FEATURE_CTRL = 5'h0a;
  localparam logic [4:0] ADDR_RESUME_ONE   = 5'h0b;
  localparam logic [4:0] ADDR_RESUME_TWO   = 5'h0c;
  localparam logic [4:0] ADDR_PAUSE_ONE    = 5'h0d;
  localparam logic [4:0] ADDR_PAUSE_TWO    = 5'h0e;
  localparam logic [4:0] ADDR_FLOW_THRESH  = 5'h0f;
  localparam logic [4:0] ADDR_FIFO_TRIGGER = 5'h10;
  localparam logic [4:0] ADDR_ALT_FUNCTION = 5'h11;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_ZERO      = 8'h00;
  localparam logic [7:0] RST_IRQ_IDENT = 8'h01;
  localparam logic [7:0] RST_LINE_CTRL = 8'h1d;
  localparam logic [7:0] RST_LINE_STAT = 8'h60;
  localparam logic [7:0] RST_ALT_FUNC  = 8'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FEAT_SPECIAL_BIT = 5;
  localparam int MCR_DTR_BIT      = 0;
  localparam int MCR_RTS_BIT      = 1;
  localparam int MCR_ANY_BIT      = 5;
  localparam int IER_PAUSE_BIT    = 5;
  localparam int LCR_BREAK_BIT    = 6;
  localparam int THRESH_SHIFT     = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    UFC_FLOW_NONE = 2'h0,
    UFC_FLOW_TWO  = 2'h1,
    UFC_FLOW_ONE  = 2'h2,
    UFC_FLOW_BOTH = 2'h3
  } ufc_flow_e;

  typedef enum logic [2:0] {
    UFC_IDLE   = 3'h1,
    UFC_FIRST  = 3'h2,
    UFC_SECOND = 3'h4
  } ufc_send_e;

  typedef struct packed {
    logic [7:0] data;
    logic       err;
  } ufc_char_s;

endpackage : ufc_pkg

// ==== verif/tb_ufc_core.sv ====
// Self-checking bench for the flow control core.
`timescale 1ns/100ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin failures++; \
  $display("unexpected %s: expected %h, seen %h", n, e, a); end end
module tb_ufc_core;
  import ufc_pkg::*;
  logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, rx_char_valid = 0, tx_fifo_full = 0;
  logic cts_n = 1, dsr_n = 1, ri_n = 1, cd_n = 1;
  logic [4:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, line_status_in = 8'h60, reg_rdata, flow_char, line_ctrl_reg, last_char;
  logic [6:0] rx_level = 0;
  logic [15:0] divisor;
  ufc_char_s rx_char = '0, fifo_char;
  logic fifo_push, tx_halt, flow_req, flow_ack, tx_serial_in, tx_pin, rts_n, dtr_n;
  logic rx_ready_out_n, tx_ready_out_n, irq_out;
  int failures = 0, samples_checked = 0, pushes = 0, acks = 0;
  logic [12:0] rows [12] = '{13'h0301, 13'h051d, 13'h0760, 13'h0800, 13'h1110, 13'h0200,
                             13'h0400, 13'h0600, 13'h0a00, 13'h0f00, 13'h1000, 13'h1f00};
  ufc_core ufc_core_inst (.*);
  ufc_tx_model #(.DLY(2)) ufc_tx_model_inst (.*);
  always #25 clk = ~clk;
  always @(posedge clk) if (fifo_push) pushes++;
  always @(posedge clk) if (flow_ack) acks++;
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 `CHK("reg_rdata", e, reg_rdata)
  endtask : rd
  task automatic rx(input logic [7:0] d, input logic e);
    @(posedge clk);
    rx_char_valid <= 1'b1;
    rx_char <= '{data: d, err: e};
    @(posedge clk);
    rx_char_valid <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : rx
  task automatic level(input logic [6:0] l);
    @(posedge clk) rx_level <= l;
    repeat (8) @(posedge clk);
  endtask : level
  task automatic stop_test;
    $display("failures %0d, samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    #1000000;
    failures++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) rd(rows[i][12:8], rows[i][7:0]);
    wr(ADDR_SCRATCH, 8'h5a);
    wr(ADDR_DIVISOR_LOW, 8'h34);
    wr(ADDR_PAUSE_ONE, 8'h13);
    wr(ADDR_RESUME_ONE, 8'h11);
    wr(ADDR_PAUSE_TWO, 8'h14);
    wr(ADDR_RESUME_TWO, 8'h12);
    wr(ADDR_MODEM_CTRL, 8'h03);
    tx_fifo_full <= 1'b1;
    rd(ADDR_MODEM_CTRL, 8'h03);
    `CHK("rts_n", 1'b0, rts_n)
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("pins", 4'he, {rts_n, dtr_n, tx_pin, tx_ready_out_n})
    rst <= 1'b0;
    rd(ADDR_SCRATCH, 8'h5a);
    `CHK("divisor", 8'h34, divisor[7:0])
    wr(ADDR_FEATURE_CTRL, 8'h0a);
    wr(ADDR_IRQ_ENABLE, 8'h20);
    rx(8'h13, 1'b1);
    `CHK("halt_pushes", 33'h1, {tx_halt, pushes})
    rx(8'h13, 1'b0);
    `CHK("halt_irq_pushes", 34'h300000001, {tx_halt, irq_out, pushes})
    rd(ADDR_IRQ_IDENT, 8'h10);
    rx(8'h11, 1'b0);
    `CHK("halt_irq", 2'h0, {tx_halt, irq_out})
    wr(ADDR_MODEM_CTRL, 8'h20);
    rx(8'h13, 1'b0);
    rx(8'h55, 1'b0);
    `CHK("halt_pushes", 33'h2, {tx_halt, pushes})
    wr(ADDR_FLOW_THRESH, 8'h12);
    level(7'd10);
    `CHK("pause_sent", 9'h013, {rx_ready_out_n, last_char})
    level(7'd4);
    `CHK("resume_sent", 8'h11, last_char)
    level(7'd10);
    wr(ADDR_FEATURE_CTRL, 8'h00);
    repeat (8) @(posedge clk);
    `CHK("resume_on_disable", 8'h11, last_char)
    wr(ADDR_PAUSE_ONE, 8'he3);
    wr(ADDR_LINE_CTRL, 8'h1c);
    wr(ADDR_FEATURE_CTRL, 8'h08);
    repeat (8) @(posedge clk);
    `CHK("pause_cut", 8'h03, last_char)
    wr(ADDR_FEATURE_CTRL, 8'h0c);
    repeat (20) @(posedge clk);
    `CHK("flow_acks", 8, acks)
    `CHK("pause_two_sent", 8'h14, last_char)
    wr(ADDR_FEATURE_CTRL, 8'h20);
    rx(8'h14, 1'b0);
    rd(ADDR_IRQ_IDENT, 8'h10);
    rd(ADDR_IRQ_IDENT, 8'h01);
    wr(ADDR_FEATURE_CTRL, 8'h0f);
    rx(8'h11, 1'b0);
    rx(8'h55, 1'b0);
    `CHK("pair_flush_pushes", 33'h5, {tx_halt, pushes})
    rx(8'h03, 1'b0);
    rx(8'h14, 1'b0);
    `CHK("pair_pause", 33'h100000005, {tx_halt, pushes})
    stop_test();
  end
endmodule : tb_ufc_core

// ==== verif/ufc_core_assertions.sv ====
// Port checker for the flow control core.
`timescale 1ns/100ps
module ufc_core_assertions
  import ufc_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       reg_wr,
  input wire logic       rx_char_valid,
  input wire ufc_char_s  rx_char,
  input wire logic       fifo_push,
  input wire logic       tx_halt,
  input wire logic       flow_req,
  input wire logic [7:0] flow_char,
  input wire logic       flow_ack,
  input wire logic       tx_pin,
  input wire logic       rts_n,
  input wire logic       dtr_n,
  input wire logic       rx_ready_out_n,
  input wire logic       tx_ready_out_n,
  input wire logic       irq_out,
  input wire logic [7:0] line_ctrl_reg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_rst_pins; $fell(rst) |-> tx_pin && rts_n && dtr_n && rx_ready_out_n && !tx_ready_out_n; endproperty
  a_rst_pins: assert property (p_rst_pins) else $error("pins not idle after reset");
  property p_lcr; $fell(rst) |-> line_ctrl_reg == 8'h1d; endproperty
  a_lcr: assert property (p_lcr) else $error("line control reset value wrong");
  property p_err_push; rx_char_valid && rx_char.err |-> ##[1:2] fifo_push; endproperty
  a_err_push: assert property (p_err_push) else $error("errored character not stored");
  property p_push_cause; fifo_push |-> $past(rx_char_valid) || $past(rx_char_valid, 2); endproperty
  a_push_cause: assert property (p_push_cause) else $error("push without received character");
  property p_flow_hold; flow_req && !flow_ack |=> flow_req && $stable(flow_char); endproperty
  a_flow_hold: assert property (p_flow_hold) else $error("flow request dropped before ack");
  property p_halt_cause; $rose(tx_halt) |-> $past(rx_char_valid); endproperty
  a_halt_cause: assert property (p_halt_cause) else $error("halt without received character");
  property p_irq_cause; $rose(irq_out) |-> $past(rx_char_valid, 2) || $past(reg_wr, 2); endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without cause");
  property p_rts_cause; $changed(rts_n) || $changed(dtr_n) |-> $past(reg_wr) || $past(reg_wr, 2); endproperty
  a_rts_cause: assert property (p_rts_cause) else $error("modem output changed without write");
endmodule : ufc_core_assertions
bind ufc_core ufc_core_assertions ufc_core_assertions_inst (.*);

// ==== verif/ufc_tx_model.sv ====
// Transmitter model that takes flow characters after a fixed delay.
`timescale 1ns/100ps
module ufc_tx_model #(
  parameter int DLY = 2
) (
  input  wire logic       clk,
  input  wire logic       flow_req,
  input  wire logic [7:0] flow_char,
  output logic            flow_ack,
  output logic            tx_serial_in,
  output logic [7:0]      last_char
);
  int wait_cnt = 0;
  initial tx_serial_in = 1'b1;
  initial flow_ack = 1'b0;
  always @(posedge clk) begin
    flow_ack <= 1'b0;
    if (flow_req && !flow_ack) begin
      wait_cnt <= (wait_cnt == DLY) ? 0 : wait_cnt + 1;
      if (wait_cnt == DLY) begin
        flow_ack <= 1'b1;
        last_char <= flow_char;
      end
    end
  end
endmodule : ufc_tx_model

// ==== verilog/ufc_core.sv ====
// In-band pause/resume flow control and register reset behaviour of one UART channel.
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/100ps
// Overview of operation
// - Transmit select bits pick pause/resume pairs
// - Receive select bits pick compared characters
// - Mixed modes accept any single character
// - Both/none transmit modes need consecutive pairs
// - Resume-any restarts on any character
// - Special character flags pause, still stored
// - Pause halts transmitter, flags, interrupt enabled
// - Resume restarts transmitter, clears pause flag
// - Errored flow characters stored as data
// - Send pause when level passes halt
// - Send resume when level falls back
// - Disabling control after pause sends resume
// - Selection change resends old resume first
// - Flow characters cut to word length
// - Unpartnered first character goes to FIFO, dropped on resume-any restart
// - Identification register resets to one
// - Line control resets to 1d
// - Line status resets with bits 5,6
// - Modem deltas clear, live bits reset to inactive
// - Alternate function resets to bit 4
// - Divisor, scratch, flow characters not reset
// - Reset drives output pins to idle
// - Pause cause decides how flag clears
module ufc_core
  import ufc_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst,
  input  wire logic [4:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic      reg_wr,
  input  wire logic      reg_rd,
  output logic [7:0]     reg_rdata,
  input  wire logic      rx_char_valid,
  input  wire ufc_char_s rx_char,
  input  wire logic [6:0] rx_level,
  output logic           fifo_push,
  output ufc_char_s      fifo_char,
  output logic           tx_halt,
  output logic           flow_req,
  output logic [7:0]     flow_char,
  input  wire logic      flow_ack,
  input  wire logic      tx_serial_in,
  input  wire logic      tx_fifo_full,
  input  wire logic [7:0] line_status_in,
  input  wire logic      cts_n,
  input  wire logic      dsr_n,
  input  wire logic      ri_n,
  input  wire logic      cd_n,
  output logic           tx_pin,
  output logic           rts_n,
  output logic           dtr_n,
  output logic           rx_ready_out_n,
  output logic           tx_ready_out_n,
  output logic           irq_out,
  output logic [7:0]     line_ctrl_reg,
  output logic [15:0]    divisor
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [7:0] mask_char(input logic [7:0] c, input logic [1:0] wl);
    case (wl)
      2'h0:    mask_char = {3'h0, c[4:0]};
      2'h1:    mask_char = {2'h0, c[5:0]};
      2'h2:    mask_char = {1'h0, c[6:0]};
      default: mask_char = c;
    endcase
  endfunction : mask_char

  function automatic logic [7:0] pick_char(input logic is_pause, input logic [1:0] sel, input logic second,
                                           input logic [7:0] on1, input logic [7:0] on2,
                                           input logic [7:0] off1, input logic [7:0] off2);
    logic use_two;
    use_two = (sel == UFC_FLOW_TWO) || second;
    if (is_pause) begin
      pick_char = use_two ? off2 : off1;
    end else begin
      pick_char = use_two ? on2 : on1;
    end
  endfunction : pick_char

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] irq_enable_reg;
  logic [7:0] fifo_ctrl_reg;
  logic [7:0] modem_ctrl_reg;
  logic [7:0] line_stat_reg;
  logic [7:0] feature_ctrl_reg;
  logic [7:0] flow_threshold_reg;
  logic [7:0] fifo_trigger_reg;
  logic [7:0] alt_function_reg;
  logic [7:0] divisor_low;
  logic [7:0] divisor_high;
  logic [7:0] scratch_reg;
  logic [7:0] resume_char_one;
  logic [7:0] resume_char_two;
  logic [7:0] pause_char_one;
  logic [7:0] pause_char_two;
  logic [3:0] modem_delta;
  logic [3:0] modem_sync1;
  logic [3:0] modem_sync2;
  logic [3:0] modem_prev;
  logic       off_flag;
  logic       spec_flag;
  logic       pend_valid;
  logic       pend_pause;
  ufc_char_s  pend_char;
  logic       hold_valid;
  ufc_char_s  hold_char;
  logic       sent_pause;
  logic [1:0] sent_sel;
  logic       send_pause;
  logic [1:0] send_sel;
  ufc_send_e  send_state;

  logic [7:0] irq_ident_reg;
  logic [7:0] modem_stat_reg;
  logic       wr_hit;
  logic       rd_ident;
  logic       rd_modem;

  assign wr_hit   = reg_wr;
  assign rd_ident = reg_rd && (reg_addr == ADDR_IRQ_IDENT);
  assign rd_modem = reg_rd && (reg_addr == ADDR_MODEM_STAT);
  assign irq_ident_reg  = {3'h0, off_flag | spec_flag, 3'h0, ~(off_flag | spec_flag)};
  assign modem_stat_reg = {~modem_sync2[3], ~modem_sync2[2], ~modem_sync2[1], ~modem_sync2[0], modem_delta};
  assign divisor = {divisor_high, divisor_low};

  // Control registers that reset.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_enable_reg     <= RST_ZERO;
      fifo_ctrl_reg      <= RST_ZERO;
      line_ctrl_reg      <= RST_LINE_CTRL;
      modem_ctrl_reg     <= RST_ZERO;
      feature_ctrl_reg   <= RST_ZERO;
      flow_threshold_reg <= RST_ZERO;
      fifo_trigger_reg   <= RST_ZERO;
      alt_function_reg   <= RST_ALT_FUNC;
    end else if (wr_hit) begin
      case (reg_addr)
        ADDR_IRQ_ENABLE:   irq_enable_reg     <= reg_wdata;
        ADDR_FIFO_CTRL:    fifo_ctrl_reg      <= reg_wdata;
        ADDR_LINE_CTRL:    line_ctrl_reg      <= reg_wdata;
        ADDR_MODEM_CTRL:   modem_ctrl_reg     <= reg_wdata;
        ADDR_FEATURE_CTRL: feature_ctrl_reg   <= reg_wdata;
        ADDR_FLOW_THRESH:  flow_threshold_reg <= reg_wdata;
        ADDR_FIFO_TRIGGER: fifo_trigger_reg   <= reg_wdata;
        ADDR_ALT_FUNCTION: alt_function_reg   <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // Registers that hold their contents through reset.
  always_ff @(posedge clk) begin
    if (wr_hit) begin
      case (reg_addr)
        ADDR_DIVISOR_LOW:  divisor_low     <= reg_wdata;
        ADDR_DIVISOR_HIGH: divisor_high    <= reg_wdata;
        ADDR_SCRATCH:      scratch_reg     <= reg_wdata;
        ADDR_RESUME_ONE:   resume_char_one <= reg_wdata;
        ADDR_RESUME_TWO:   resume_char_two <= reg_wdata;
        ADDR_PAUSE_ONE:    pause_char_one  <= reg_wdata;
        ADDR_PAUSE_TWO:    pause_char_two  <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // Line status follows the rest of the channel once out of reset.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      line_stat_reg <= RST_LINE_STAT;
    end else begin
      line_stat_reg <= line_status_in;
    end
  end

  // ----------------------------------------------------------------
  // Modem inputs and change flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      modem_sync1 <= 4'hf;
      modem_sync2 <= 4'hf;
      modem_prev  <= 4'hf;
    end else begin
      modem_sync1 <= {cd_n, ri_n, dsr_n, cts_n};
      modem_sync2 <= modem_sync1;
      modem_prev  <= modem_sync2;
    end
  end

  // A change seen in the same cycle as a status read survives the read.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      modem_delta <= 4'h0;
    end else begin
      modem_delta[0] <= (modem_sync2[0] != modem_prev[0]) | (modem_delta[0] & ~rd_modem);
      modem_delta[1] <= (modem_sync2[1] != modem_prev[1]) | (modem_delta[1] & ~rd_modem);
      modem_delta[2] <= (modem_sync2[2] & ~modem_prev[2]) | (modem_delta[2] & ~rd_modem);
      modem_delta[3] <= (modem_sync2[3] != modem_prev[3]) | (modem_delta[3] & ~rd_modem);
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= RST_ZERO;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_DIVISOR_LOW:  reg_rdata <= divisor_low;
        ADDR_DIVISOR_HIGH: reg_rdata <= divisor_high;
        ADDR_IRQ_ENABLE:   reg_rdata <= irq_enable_reg;
        ADDR_IRQ_IDENT:    reg_rdata <= irq_ident_reg;
        ADDR_FIFO_CTRL:    reg_rdata <= fifo_ctrl_reg;
        ADDR_LINE_CTRL:    reg_rdata <= line_ctrl_reg;
        ADDR_MODEM_CTRL:   reg_rdata <= modem_ctrl_reg;
        ADDR_LINE_STAT:    reg_rdata <= line_stat_reg;
        ADDR_MODEM_STAT:   reg_rdata <= modem_stat_reg;
        ADDR_SCRATCH:      reg_rdata <= scratch_reg;
        ADDR_FEATURE_CTRL: reg_rdata <= feature_ctrl_reg;
        ADDR_RESUME_ONE:   reg_rdata <= resume_char_one;
        ADDR_RESUME_TWO:   reg_rdata <= resume_char_two;
        ADDR_PAUSE_ONE:    reg_rdata <= pause_char_one;
        ADDR_PAUSE_TWO:    reg_rdata <= pause_char_two;
        ADDR_FLOW_THRESH:  reg_rdata <= flow_threshold_reg;
        ADDR_FIFO_TRIGGER: reg_rdata <= fifo_trigger_reg;
        ADDR_ALT_FUNCTION: reg_rdata <= alt_function_reg;
        default:           reg_rdata <= RST_ZERO;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receive character matching
  // ----------------------------------------------------------------
  logic [1:0] rx_sel;
  logic [1:0] tx_sel;
  logic [7:0] cur;
  logic       ok;
  logic       on1;
  logic       on2;
  logic       off1;
  logic       off2;
  logic       single_any;
  logic       pair_mode;
  logic       single_on;
  logic       single_off;
  logic       cmd_on;
  logic       cmd_off;
  logic       special;
  logic       cur_push;
  logic       pend_new;

  assign rx_sel = feature_ctrl_reg[1:0];
  assign tx_sel = feature_ctrl_reg[3:2];
  assign cur    = mask_char(rx_char.data, line_ctrl_reg[1:0]);
  assign ok     = ~rx_char.err;
  assign on1    = cur == mask_char(resume_char_one, line_ctrl_reg[1:0]);
  assign on2    = cur == mask_char(resume_char_two, line_ctrl_reg[1:0]);
  assign off1   = cur == mask_char(pause_char_one, line_ctrl_reg[1:0]);
  assign off2   = cur == mask_char(pause_char_two, line_ctrl_reg[1:0]);
  assign single_any = (rx_sel == UFC_FLOW_BOTH) && ((tx_sel == UFC_FLOW_ONE) || (tx_sel == UFC_FLOW_TWO));
  assign pair_mode  = (rx_sel == UFC_FLOW_BOTH) && !single_any;
  assign single_on  = ok && (((rx_sel == UFC_FLOW_ONE) && on1) || ((rx_sel == UFC_FLOW_TWO) && on2)
                      || (single_any && (on1 || on2)));
  assign single_off = ok && (((rx_sel == UFC_FLOW_ONE) && off1) || ((rx_sel == UFC_FLOW_TWO) && off2)
                      || (single_any && (off1 || off2)));

  always_comb begin
    cmd_on   = 1'b0;
    cmd_off  = 1'b0;
    cur_push = 1'b0;
    pend_new = 1'b0;
    special  = 1'b0;
    if (rx_char_valid) begin
      if (pend_valid && ok && (pend_pause ? off2 : on2)) begin
        cmd_on  = !pend_pause;
        cmd_off = pend_pause;
      end else if (single_off) begin
        cmd_off = 1'b1;
      end else if (single_on) begin
        cmd_on = 1'b1;
      end else if (tx_halt && modem_ctrl_reg[MCR_ANY_BIT]) begin
        cmd_on   = 1'b1;
        cur_push = 1'b1;
      end else if (pair_mode && ok && (on1 || off1)) begin
        pend_new = 1'b1;
      end else begin
        cur_push = 1'b1;
      end
      special = cur_push && ok && off2 && feature_ctrl_reg[FEAT_SPECIAL_BIT];
    end
  end

  // Pending first character of a pair.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_valid <= 1'b0;
      pend_pause <= 1'b0;
      pend_char  <= '0;
    end else if (rx_char_valid) begin
      pend_valid <= pend_new;
      pend_pause <= off1;
      pend_char  <= rx_char;
    end
  end

  // A flushed pair head goes out first and the current character one cycle later.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fifo_push  <= 1'b0;
      fifo_char  <= '0;
      hold_valid <= 1'b0;
      hold_char  <= '0;
    end else if (rx_char_valid && pend_valid && !(cmd_on || cmd_off) ) begin
      fifo_push  <= 1'b1;
      fifo_char  <= pend_char;
      hold_valid <= cur_push;
      hold_char  <= rx_char;
    end else if (rx_char_valid && cur_push) begin
      fifo_push  <= 1'b1;
      fifo_char  <= rx_char;
      hold_valid <= 1'b0;
    end else begin
      fifo_push  <= hold_valid;
      fifo_char  <= hold_char;
      hold_valid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Transmitter halt and pause flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_halt <= 1'b0;
    end else if (cmd_off) begin
      tx_halt <= 1'b1;
    end else if (cmd_on || (rx_sel == UFC_FLOW_NONE)) begin
      tx_halt <= 1'b0;
    end
  end

  // Each flag is cleared only by its own cause; a set in the clearing cycle wins.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      off_flag  <= 1'b0;
      spec_flag <= 1'b0;
    end else begin
      off_flag  <= cmd_off | (off_flag & ~cmd_on);
      spec_flag <= special | (spec_flag & ~rd_ident);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= (off_flag | spec_flag) & irq_enable_reg[IER_PAUSE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Flow character sender
  // ----------------------------------------------------------------
  logic [5:0] halt_level;
  logic [5:0] resume_level;
  logic       want_pause;
  logic       want_resume;

  assign halt_level   = {flow_threshold_reg[3:0], 2'h0};
  assign resume_level = {flow_threshold_reg[7:4], 2'h0};
  assign want_pause   = !sent_pause && (tx_sel != UFC_FLOW_NONE) && (rx_level > {1'b0, halt_level});
  assign want_resume  = sent_pause && ((rx_level <= {1'b0, resume_level}) || (tx_sel != sent_sel));
  assign flow_req     = send_state != UFC_IDLE;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      send_state <= UFC_IDLE;
      sent_pause <= 1'b0;
      sent_sel   <= UFC_FLOW_NONE;
      send_pause <= 1'b0;
      send_sel   <= UFC_FLOW_NONE;
      flow_char  <= RST_ZERO;
    end else begin
      case (send_state)
        UFC_IDLE: begin
          if (want_resume) begin
            send_state <= UFC_FIRST;
            sent_pause <= 1'b0;
            send_pause <= 1'b0;
            send_sel   <= sent_sel;
            flow_char  <= mask_char(pick_char(1'b0, sent_sel, 1'b0, resume_char_one, resume_char_two,
                                              pause_char_one, pause_char_two), line_ctrl_reg[1:0]);
          end else if (want_pause) begin
            send_state <= UFC_FIRST;
            sent_pause <= 1'b1;
            sent_sel   <= tx_sel;
            send_pause <= 1'b1;
            send_sel   <= tx_sel;
            flow_char  <= mask_char(pick_char(1'b1, tx_sel, 1'b0, resume_char_one, resume_char_two,
                                              pause_char_one, pause_char_two), line_ctrl_reg[1:0]);
          end
        end
        UFC_FIRST: begin
          if (flow_ack && (send_sel == UFC_FLOW_BOTH)) begin
            send_state <= UFC_SECOND;
            flow_char  <= mask_char(pick_char(send_pause, send_sel, 1'b1, resume_char_one, resume_char_two,
                                              pause_char_one, pause_char_two), line_ctrl_reg[1:0]);
          end else if (flow_ack) begin
            send_state <= UFC_IDLE;
          end
        end
        UFC_SECOND: begin
          if (flow_ack) begin
            send_state <= UFC_IDLE;
          end
        end
        default: send_state <= UFC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Output pins
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_pin         <= 1'b1;
      rts_n          <= 1'b1;
      dtr_n          <= 1'b1;
      rx_ready_out_n <= 1'b1;
      tx_ready_out_n <= 1'b0;
    end else begin
      tx_pin         <= tx_serial_in & ~line_ctrl_reg[LCR_BREAK_BIT];
      rts_n          <= ~modem_ctrl_reg[MCR_RTS_BIT];
      dtr_n          <= ~modem_ctrl_reg[MCR_DTR_BIT];
      rx_ready_out_n <= rx_level == 7'h00;
      tx_ready_out_n <= tx_fifo_full;
    end
  end

endmodule : ufc_core
